// *** iodig_board.sv ***
// Peripheral board end: device decode, pointers, request flags.
// Assumes the processor end drives the link from its own flops.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`include "iodig_map.svh"
`default_nettype none
module iodig_board
    import iodig_pkg::*;
#(
    parameter int NPORT = 7
) (
    input wire logic clock,
    input wire logic arst_n,
    iodig_if.board bus,
    input wire logic [NPORT*8-1:0] port_status, // Per-port status
    input wire logic [NPORT*8-1:0] port_rx, // Per-port receive data
    input wire logic [NPORT*3-1:0] baud_strap, // Per-port rate strap
    input wire logic [15:0] disc_status,
    input wire logic [15:0] tape_status,
    input wire logic [2:0] mod_done, // Transfer done: mux, disc, tape
    input wire logic [2:0] mod_event, // Status change or error
    input wire logic [2:0] mod_dma_req, // DMA wanted per module
    input wire logic disc_word_stb, // One disc word moved
    output logic [2:0] mod_dma_go,
    output logic port_cmd_wr, // Pulse: load port command
    output logic port_tx_wr, // Pulse: load port transmit data
    output logic [2:0] port_sel_r,
    output logic [7:0] port_wdata_r,
    output logic disc_wr, // Pulse: disc register write
    output logic tape_wr, // Pulse: tape register write
    output logic [1:0] ctl_reg_r, // Register within disc/tape group
    output logic [15:0] ctl_wdata_r,
    output logic disc_drive_r, // Selected disc drive
    output logic [1:0] tape_drive_r, // Selected tape drive
    output logic [NPORT*3-1:0] baud_sel_r, // Caught rate straps
    output logic [8:0] sector_word_r, // Word in sector
    output logic sector_header, // Word lies in header
    output logic [47:0] dma_ptr // Pointers mux, disc, tape
);
    // ==========
    // Decode helpers
    // Serial port index from a device code, 7 when none
    function automatic logic [2:0] port_of(input logic [5:0] dev);
        logic [2:0] idx;
        idx = 3'h7;
        if (dev >= `IODIG_DEV_PORT0 && dev <= `IODIG_DEV_PORT3_ODD) begin
            idx = 3'((dev - `IODIG_DEV_PORT0) >> 1);
        end else if (dev >= `IODIG_DEV_PORT4
                && dev <= `IODIG_DEV_PORT6_ODD) begin
            idx = 3'((dev - `IODIG_DEV_PORT4) >> 1) + 3'h4;
        end
        if (idx >= 3'(NPORT)) begin
            idx = 3'h7;
        end
        return idx;
    endfunction

    // ==========
    // State
    logic [15:0] ptr_r [3]; // Descriptor-block pointers
    logic [2:0] pend_r, pend_nxt; // Pending bits seen by software
    logic [2:0] req_r, req_nxt; // Request flags seen by processor
    logic [15:0] rdata_r, rdata_nxt;
    logic hit_r, hit_nxt;
    logic strap_done_r; // Straps caught once after release
    logic [15:0] ptr_nxt [3];
    logic [2:0] port_sel_nxt;
    logic [7:0] port_wdata_nxt;
    logic [1:0] ctl_reg_nxt;
    logic [15:0] ctl_wdata_nxt;
    logic disc_drive_nxt;
    logic [1:0] tape_drive_nxt;
    logic [8:0] sector_word_nxt;
    logic cmd_wr_nxt, tx_wr_nxt, disc_wr_nxt, tape_wr_nxt;
    logic cmd_wr_r, tx_wr_r, disc_wr_r, tape_wr_r;

    // ==========
    // Next-state logic
    // All modules feed one request line: no priority among them
    always_comb begin
        logic [2:0] pidx;
        logic [1:0] qsel;
        logic is_disc, is_tape;
        pidx = port_of(bus.io_dev);
        qsel = 2'h0;
        is_disc = bus.io_dev >= `IODIG_DEV_DISC_LO
            && bus.io_dev <= `IODIG_DEV_DISC_HI;
        is_tape = bus.io_dev >= `IODIG_DEV_TAPE_LO
            && bus.io_dev <= `IODIG_DEV_TAPE_HI;
        pend_nxt = pend_r;
        req_nxt = req_r;
        rdata_nxt = 16'h0000;
        hit_nxt = 1'b0;
        ptr_nxt = ptr_r;
        port_sel_nxt = port_sel_r;
        port_wdata_nxt = port_wdata_r;
        ctl_reg_nxt = ctl_reg_r;
        ctl_wdata_nxt = ctl_wdata_r;
        disc_drive_nxt = disc_drive_r;
        tape_drive_nxt = tape_drive_r;
        cmd_wr_nxt = 1'b0;
        tx_wr_nxt = 1'b0;
        disc_wr_nxt = 1'b0;
        tape_wr_nxt = 1'b0;
        // Acknowledge drops the processor-side flags
        if (bus.int_ack) begin
            req_nxt = 3'h0;
        end
        if (bus.io_strobe) begin
            case (bus.io_kind)
                IODIG_PRD: begin
                    if (pidx != 3'h7) begin
                        hit_nxt = 1'b1;
                        rdata_nxt = bus.io_dev[0]
                            ? {8'h00, port_rx[pidx*8 +: 8]}
                            : {8'h00, port_status[pidx*8 +: 8]};
                    end else if (is_disc) begin
                        hit_nxt = 1'b1;
                        rdata_nxt = disc_status;
                    end else if (is_tape) begin
                        hit_nxt = 1'b1;
                        rdata_nxt = tape_status;
                    end
                end
                IODIG_PWR: begin
                    if (pidx != 3'h7) begin
                        hit_nxt = 1'b1;
                        port_sel_nxt = pidx;
                        port_wdata_nxt = bus.io_wdata[7:0];
                        cmd_wr_nxt = !bus.io_dev[0];
                        tx_wr_nxt = bus.io_dev[0];
                    end else if (is_disc) begin
                        hit_nxt = 1'b1;
                        disc_wr_nxt = 1'b1;
                        ctl_wdata_nxt = bus.io_wdata;
                        // Upper three codes reach the second drive
                        disc_drive_nxt =
                            bus.io_dev >= `IODIG_DEV_DISC_D1;
                        ctl_reg_nxt = disc_drive_nxt
                            ? 2'(bus.io_dev - `IODIG_DEV_DISC_D1)
                            : 2'(bus.io_dev - `IODIG_DEV_DISC_LO);
                    end else if (is_tape) begin
                        hit_nxt = 1'b1;
                        tape_wr_nxt = 1'b1;
                        ctl_wdata_nxt = bus.io_wdata;
                        ctl_reg_nxt = 2'(bus.io_dev - `IODIG_DEV_TAPE_LO);
                        if (bus.io_dev == `IODIG_DEV_TAPE_HI) begin
                            tape_drive_nxt = bus.io_wdata[1:0];
                        end
                    end
                end
                default: begin
                    // Pointer traffic only on the processor code
                    if (bus.io_dev == `IODIG_DEV_CPU
                            && bus.io_ctl != 2'h0) begin
                        qsel = bus.io_ctl - 2'h1;
                        hit_nxt = 1'b1;
                        if (bus.io_kind == IODIG_QRD) begin
                            rdata_nxt = {pend_r[qsel],
                                ptr_r[qsel][14:0]};
                        end else begin
                            ptr_nxt[qsel] = {1'b0, bus.io_wdata[14:0]};
                            // Software drops pending by writing MSB 0
                            if (!bus.io_wdata[`IODIG_PEND_BIT]) begin
                                pend_nxt[qsel] = 1'b0;
                            end
                        end
                    end
                end
            endcase
        end
        // A new event beats any clear in the same cycle
        pend_nxt = pend_nxt | mod_done | mod_event;
        req_nxt = req_nxt | mod_done | mod_event;
        sector_word_nxt = sector_word_r;
        if (disc_word_stb) begin
            sector_word_nxt = (sector_word_r == `IODIG_SECT_LAST)
                ? 9'h000 : sector_word_r + 9'h001;
        end
    end

    // ==========
    // Registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ptr_r <= '{default: 16'h0000};
            pend_r <= 3'h0;
            req_r <= 3'h0;
            rdata_r <= 16'h0000;
            hit_r <= 1'b0;
            port_sel_r <= 3'h0;
            port_wdata_r <= 8'h00;
            ctl_reg_r <= 2'h0;
            ctl_wdata_r <= 16'h0000;
            disc_drive_r <= 1'b0;
            tape_drive_r <= 2'h0;
            sector_word_r <= 9'h000;
            cmd_wr_r <= 1'b0;
            tx_wr_r <= 1'b0;
            disc_wr_r <= 1'b0;
            tape_wr_r <= 1'b0;
            strap_done_r <= 1'b0;
            baud_sel_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
            pend_r <= pend_nxt;
            req_r <= req_nxt;
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
            port_sel_r <= port_sel_nxt;
            port_wdata_r <= port_wdata_nxt;
            ctl_reg_r <= ctl_reg_nxt;
            ctl_wdata_r <= ctl_wdata_nxt;
            disc_drive_r <= disc_drive_nxt;
            tape_drive_r <= tape_drive_nxt;
            sector_word_r <= sector_word_nxt;
            cmd_wr_r <= cmd_wr_nxt;
            tx_wr_r <= tx_wr_nxt;
            disc_wr_r <= disc_wr_nxt;
            tape_wr_r <= tape_wr_nxt;
            // Straps caught on the first edge after release only
            strap_done_r <= 1'b1;
            if (!strap_done_r) begin
                baud_sel_r <= baud_strap;
            end
        end
    end

    // ==========
    // Outputs
    assign bus.io_rdata = rdata_r;
    assign bus.io_hit = hit_r;
    assign bus.irq_req = |req_r;
    assign mod_dma_go = mod_dma_req & {3{bus.dma_enable}};
    assign bus.dma_wait = |mod_dma_go;
    assign port_cmd_wr = cmd_wr_r;
    assign port_tx_wr = tx_wr_r;
    assign disc_wr = disc_wr_r;
    assign tape_wr = tape_wr_r;
    assign sector_header = sector_word_r < `IODIG_SECT_HDR;
    assign dma_ptr = {ptr_r[2], ptr_r[1], ptr_r[0]};
endmodule
`default_nettype wire

// *** iodig_chk.sv ***
// Checker on the backplane link between the two design ends.
// Assumes one clock; placed beside the link by the bench.
`default_nettype none
module iodig_chk
    import iodig_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic io_strobe,
    input wire iodig_kind_t io_kind,
    input wire logic [5:0] io_dev,
    input wire logic [1:0] io_ctl,
    input wire logic [15:0] io_rdata,
    input wire logic io_hit,
    input wire logic irq_req,
    input wire logic dma_wait,
    input wire logic int_ack,
    input wire logic dma_enable
);
    // ==========
    // Decode helpers
    logic prog; // Programmed cycle
    logic gap; // Code nobody owns
    assign prog = io_strobe && !io_kind[1];
    assign gap = io_dev < 6'h08 || (io_dev > 6'h15 && io_dev < 6'h28);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ==========
    // Link properties
    a_hit_cause: assert property (io_hit |-> $past(io_strobe))
        else $error("hit without request");
    a_gap_silent: assert property (io_strobe && gap |=>
        !io_hit && io_rdata == 16'h0000) else $error("free code taken");
    a_port_claim: assert property (prog && io_dev inside
        {[6'h08:6'h15]} |=> io_hit) else $error("port not claimed");
    a_ptr_claim: assert property (io_strobe && io_kind[1] &&
        io_dev == 6'h3f |=> io_hit == (io_ctl != 2'h0))
        else $error("pointer claim wrong");
    a_take_gate: assert property (int_ack |->
        $past(irq_req) && !$past(dma_wait)) else $error("bad accept");
    a_ack_single: assert property (int_ack |=> !int_ack)
        else $error("double accept");
    a_flag_hold: assert property ($fell(irq_req) |-> $past(int_ack) ||
        $past(io_strobe && io_kind == IODIG_QWR)) else $error("flag lost");
    a_dma_gate: assert property (!dma_enable |-> !dma_wait)
        else $error("dma wait while off");
    // Main scenarios reached
    c_ack: cover property (int_ack);
    c_ptr: cover property (io_strobe && io_kind[1] ##1 io_hit);
    c_dma_off: cover property (!dma_enable);
endmodule
`default_nettype wire

// *** iodig_if.sv ***
// Backplane I/O link between processor end and peripheral board.
// Assumes one shared clock; all but the board's dma_wait are driven from flip-flops.
`default_nettype none
interface iodig_if;
    import iodig_pkg::*;
    logic io_strobe; // One-cycle I/O request
    iodig_kind_t io_kind; // Kind of request
    logic [5:0] io_dev; // Device code
    logic [1:0] io_ctl; // Control field
    logic [15:0] io_wdata; // Write data
    logic [15:0] io_rdata; // Read data, cycle after strobe
    logic io_hit; // Board claimed the request, with rdata
    logic irq_req; // Any module request flag
    logic dma_wait; // Some module waits for DMA
    logic int_ack; // Processor took an interrupt
    logic dma_enable; // DMA allowed to controllers
    modport proc (output io_strobe, io_kind, io_dev, io_ctl, io_wdata,
        int_ack, dma_enable, input io_rdata, io_hit, irq_req, dma_wait);
    modport board (input io_strobe, io_kind, io_dev, io_ctl, io_wdata,
        int_ack, dma_enable, output io_rdata, io_hit, irq_req, dma_wait);
endinterface
`default_nettype wire

// *** iodig_map.svh ***
// Constants shared by both ends of the backplane I/O link.
// Assumes inclusion by bare name before any module that uses it.
// Notes on behaviour
// - Serial ports decode as code pairs 10-25
// - Even code status/command, odd code data
// - Disc answers 50-55, tape 60-62
// - Pointer access on 77, control field picks
// - Processor skip tests on code 77
// - Interrupt taken on four joint conditions
// - Save PC at 0, jump via 1
// - Acceptance clears global enable until software
// - One shared priority level, no ordering
// - Odd masks, even unmasks interrupts
// - Exactly 1 stops DMA, 0 starts
// - Per-port baud strap, eight rates
// - Sector: 4 header, 256 data words
// - Disc two drives, tape four drives
// - Each module individually addressable by decode
// - Pending interrupt in pointer MSB
// - Request on completion, status change, error
`ifndef IODIG_MAP_SVH
`define IODIG_MAP_SVH
// ==========
// Device codes, octal values written in hex
`define IODIG_DEV_PORT0 6'h08
`define IODIG_DEV_PORT3_ODD 6'h0f
`define IODIG_DEV_PORT4 6'h10
`define IODIG_DEV_PORT6_ODD 6'h15
`define IODIG_DEV_DISC_LO 6'h28
`define IODIG_DEV_DISC_D1 6'h2b
`define IODIG_DEV_DISC_HI 6'h2d
`define IODIG_DEV_TAPE_LO 6'h30
`define IODIG_DEV_TAPE_HI 6'h32
`define IODIG_DEV_CPU 6'h3f
// ==========
// Pointer layout and control field
`define IODIG_PEND_BIT 15
`define IODIG_CTL_MUX 2'h1
`define IODIG_CTL_DISC 2'h2
`define IODIG_CTL_TAPE 2'h3
// ==========
// Sector shape
`define IODIG_SECT_HDR 9'h004
`define IODIG_SECT_LAST 9'h103
// ==========
// Host command register layout and register map
`define IODIG_CMD_DEV 5:0
`define IODIG_CMD_CTL 7:6
`define IODIG_CMD_OP 10:8
`define IODIG_RA_CMD 3'h0
`define IODIG_RA_ACC 3'h1
`define IODIG_RA_STAT 3'h2
`define IODIG_RA_PC 3'h3
`define IODIG_RA_VEC 3'h4
`define IODIG_RA_SAVE 3'h5
`define IODIG_RA_FETCH 3'h6
`define IODIG_MSK_DMA_OFF 16'h0001
`define IODIG_MSK_DMA_ON 16'h0000
`endif

// *** iodig_pkg.sv ***
// Types shared by both ends of the backplane I/O link.
// Assumes the map header is compiled alongside.
`default_nettype none
package iodig_pkg;
    // ==========
    // Kind of bus cycle on the link
    typedef enum logic [1:0] {
        IODIG_PRD = 2'h0, // Programmed read
        IODIG_PWR = 2'h1, // Programmed write
        IODIG_QRD = 2'h2, // Pointer read
        IODIG_QWR = 2'h3  // Pointer write
    } iodig_kind_t;
    // Host instruction op field
    typedef enum logic [2:0] {
        IODIG_OP_PRD = 3'h0,
        IODIG_OP_PWR = 3'h1,
        IODIG_OP_QRD = 3'h2,
        IODIG_OP_QWR = 3'h3,
        IODIG_OP_SKIP = 3'h4,
        IODIG_OP_MASK = 3'h5,
        IODIG_OP_IEN = 3'h6,
        IODIG_OP_IDS = 3'h7
    } iodig_op_t;
endpackage
`default_nettype wire

// *** iodig_proc.sv ***
// Processor end: issues I/O, keeps enable and mask, takes interrupts.
// Assumes software on a plain register port, read data a cycle late.
`include "iodig_map.svh"
`default_nettype none
module iodig_proc
    import iodig_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    iodig_if.proc bus,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic power_fail, // Power failure seen
    output logic [15:0] reg_rdata
);
    // ==========
    // State
    logic ion_r, ion_nxt; // Global enable
    logic mask_r, mask_nxt; // Interrupts masked out
    logic dma_en_r, dma_en_nxt;
    logic skip_r, skip_nxt; // Last skip test result
    logic [15:0] acc_r, acc_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] vec_r, vec_nxt; // Content of location 1
    logic [15:0] save_r, save_nxt; // Content of location 0
    logic rd_pend_r, rd_pend_nxt; // Waiting for board answer
    logic stb_r, stb_nxt;
    iodig_kind_t kind_r, kind_nxt;
    logic [5:0] dev_r, dev_nxt;
    logic [1:0] ctl_r, ctl_nxt;
    logic [15:0] wd_r, wd_nxt;
    logic ack_r, ack_nxt;
    logic [15:0] rdata_r, rdata_nxt;

    // ==========
    // Next-state logic
    always_comb begin
        iodig_op_t op;
        logic [5:0] dev;
        logic [1:0] ctl;
        op = iodig_op_t'(reg_wdata[`IODIG_CMD_OP]);
        dev = reg_wdata[`IODIG_CMD_DEV];
        ctl = reg_wdata[`IODIG_CMD_CTL];
        {ion_nxt, mask_nxt, dma_en_nxt, skip_nxt} =
            {ion_r, mask_r, dma_en_r, skip_r};
        {acc_nxt, pc_nxt, vec_nxt, save_nxt} = {acc_r, pc_r, vec_r, save_r};
        // Board answers one cycle after the strobe
        rd_pend_nxt = stb_r && !kind_r[0];
        stb_nxt = 1'b0;
        {kind_nxt, dev_nxt, ctl_nxt, wd_nxt} = {kind_r, dev_r, ctl_r, wd_r};
        ack_nxt = 1'b0;
        rdata_nxt = 16'h0000;
        // Board answer lands in the accumulator
        if (rd_pend_r && bus.io_hit) begin
            acc_nxt = bus.io_rdata;
        end
        if (reg_wr) begin
            case (reg_addr)
                `IODIG_RA_CMD: begin
                    case (op)
                        IODIG_OP_SKIP: begin
                            if (dev == `IODIG_DEV_CPU) begin
                                case (ctl)
                                    2'h0: skip_nxt = ion_r;
                                    2'h1: skip_nxt = !ion_r;
                                    2'h2: skip_nxt = power_fail;
                                    default: skip_nxt = !power_fail;
                                endcase
                            end
                        end
                        IODIG_OP_MASK: begin
                            if (acc_r == `IODIG_MSK_DMA_OFF) begin
                                dma_en_nxt = 1'b0;
                            end else if (acc_r == `IODIG_MSK_DMA_ON) begin
                                dma_en_nxt = 1'b1;
                            end else begin
                                mask_nxt = acc_r[0];
                            end
                        end
                        IODIG_OP_IEN: ion_nxt = 1'b1;
                        IODIG_OP_IDS: ion_nxt = 1'b0;
                        default: begin
                            // Ops 0 to 3 map straight onto the link
                            stb_nxt = 1'b1;
                            kind_nxt = iodig_kind_t'(op[1:0]);
                            dev_nxt = dev;
                            ctl_nxt = ctl;
                            wd_nxt = acc_r;
                        end
                    endcase
                end
                `IODIG_RA_ACC: acc_nxt = reg_wdata;
                `IODIG_RA_PC: pc_nxt = reg_wdata;
                `IODIG_RA_VEC: vec_nxt = reg_wdata;
                `IODIG_RA_FETCH: begin
                    // Fetch done: single level, any flag qualifies
                    if (bus.irq_req && ion_r && !mask_r
                            && !bus.dma_wait) begin
                        save_nxt = pc_r;
                        pc_nxt = vec_r;
                        ion_nxt = 1'b0;
                        ack_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `IODIG_RA_ACC: rdata_nxt = acc_r;
                `IODIG_RA_STAT: rdata_nxt = {9'h000, rd_pend_r,
                    bus.irq_req, bus.dma_wait, skip_r, dma_en_r,
                    mask_r, ion_r};
                `IODIG_RA_PC: rdata_nxt = pc_r;
                `IODIG_RA_VEC: rdata_nxt = vec_r;
                `IODIG_RA_SAVE: rdata_nxt = save_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // ==========
    // Registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ion_r <= 1'b0;
            mask_r <= 1'b0;
            dma_en_r <= 1'b1;
            skip_r <= 1'b0;
            acc_r <= 16'h0000;
            pc_r <= 16'h0000;
            vec_r <= 16'h0000;
            save_r <= 16'h0000;
            rd_pend_r <= 1'b0;
            stb_r <= 1'b0;
            kind_r <= IODIG_PRD;
            dev_r <= 6'h00;
            ctl_r <= 2'h0;
            wd_r <= 16'h0000;
            ack_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            ion_r <= ion_nxt;
            mask_r <= mask_nxt;
            dma_en_r <= dma_en_nxt;
            skip_r <= skip_nxt;
            acc_r <= acc_nxt;
            pc_r <= pc_nxt;
            vec_r <= vec_nxt;
            save_r <= save_nxt;
            rd_pend_r <= rd_pend_nxt;
            stb_r <= stb_nxt;
            kind_r <= kind_nxt;
            dev_r <= dev_nxt;
            ctl_r <= ctl_nxt;
            wd_r <= wd_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========
    // Outputs
    assign bus.io_strobe = stb_r;
    assign bus.io_kind = kind_r;
    assign bus.io_dev = dev_r;
    assign bus.io_ctl = ctl_r;
    assign bus.io_wdata = wd_r;
    assign bus.int_ack = ack_r;
    assign bus.dma_enable = dma_en_r;
    assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Bench for both link ends, driven through the software port.
// Assumes the map header, package, link and both ends compile first.
`include "iodig_map.svh"
`default_nettype none
module tb_top
    import iodig_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Stimulus and observed signals
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic power_fail = 1'b0;
    logic [55:0] port_status;
    logic [55:0] port_rx;
    logic [2:0] mod_done = 3'h0;
    logic [2:0] mod_event = 3'h0;
    logic [2:0] mod_dma_req = 3'h0;
    logic [2:0] mod_dma_go;
    logic port_cmd_wr;
    logic port_tx_wr;
    logic [1:0] pw; // Write pulses caught in their cycle
    logic [2:0] port_sel_r;
    logic [7:0] port_wdata_r;
    logic [20:0] baud_sel_r;
    logic [47:0] dma_ptr;
    logic [5:0] d;
    int miscompares = 0;
    int tests_run = 0;
    int acks = 0; // Accepted interrupts
    iodig_if bus ();
    iodig_board i_iodig_board (.clock, .arst_n, .bus(bus.board),
        .port_status, .port_rx, .baud_strap(21'h0fac53),
        .disc_status(16'hd15c), .tape_status(16'h7a9e), .mod_done,
        .mod_event, .mod_dma_req, .disc_word_stb(1'b0), .mod_dma_go,
        .port_cmd_wr, .port_tx_wr, .port_sel_r, .port_wdata_r, .disc_wr(),
        .tape_wr(), .ctl_reg_r(), .ctl_wdata_r(), .disc_drive_r(),
        .tape_drive_r(), .baud_sel_r, .sector_word_r(), .sector_header(),
        .dma_ptr);
    iodig_proc i_iodig_proc (.clock, .arst_n, .bus(bus.proc), .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .power_fail, .reg_rdata);
    iodig_chk i_iodig_chk (.clock, .arst_n,
        .io_strobe(bus.io_strobe), .io_kind(bus.io_kind),
        .io_dev(bus.io_dev), .io_ctl(bus.io_ctl), .io_rdata(bus.io_rdata),
        .io_hit(bus.io_hit), .irq_req(bus.irq_req),
        .dma_wait(bus.dma_wait), .int_ack(bus.int_ack),
        .dma_enable(bus.dma_enable));
    always #25 clock = ~clock;
    // Count accepted interrupts
    always @(posedge clock) if (bus.int_ack === 1'b1) acks <= acks + 1;
    // ==========
    // Access tasks, each entered just after a rising edge
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rc(input logic [2:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clock);
        #1 chk(reg_rdata, e);
    endtask
    // Strobes low, then let edges pass
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    // One instruction, then let the link answer
    task automatic op(input logic [2:0] o, input logic [1:0] c,
        input logic [5:0] dv, input logic [15:0] acc);
        wr(`IODIG_RA_ACC, acc);
        wr(`IODIG_RA_CMD, {5'h00, o, c, dv});
        idle(1);
        #1 pw = {port_cmd_wr, port_tx_wr};
        repeat (2) @(posedge clock);
    endtask
    task automatic ft(input int n);
        wr(`IODIG_RA_FETCH, 16'h0000);
        idle(3);
        chk(16'(acks), 16'(n));
    endtask
    task automatic test_done();
        $display("Compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #400000;
        miscompares++;
        test_done();
    end
    // ==========
    // Main sequence
    initial begin
        for (int i = 0; i < 7; i++) begin
            port_status[i*8+:8] = 8'h30 + 8'(i);
            port_rx[i*8+:8] = 8'hc0 + 8'(i);
        end
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rc(`IODIG_RA_STAT, 16'h0004); // Reset state
        chk(baud_sel_r[15:0], 16'hac53);
        for (int p = 0; p < 7; p++) begin
            d = (p < 4) ? 6'h08 + 6'(2 * p) : 6'h10 + 6'(2 * (p - 4));
            op(IODIG_OP_PRD, 2'h0, d, 16'hdead);
            rc(`IODIG_RA_ACC, {8'h00, port_status[p*8+:8]});
            op(IODIG_OP_PRD, 2'h0, d + 6'h01, 16'hdead);
            rc(`IODIG_RA_ACC, {8'h00, port_rx[p*8+:8]});
            op(IODIG_OP_PWR, 2'h0, d + 6'(p % 2), 16'h0050 + 16'(p));
            chk({3'h0, pw, port_sel_r, port_wdata_r}, {3'h0,
                (p % 2 == 1) ? 2'h1 : 2'h2, 3'(p), 8'h50 + 8'(p)});
        end
        op(IODIG_OP_PRD, 2'h0, 6'h16, 16'h1234);
        rc(`IODIG_RA_ACC, 16'h1234);
        op(IODIG_OP_PRD, 2'h0, 6'h2b, 16'h0000);
        rc(`IODIG_RA_ACC, 16'hd15c);
        op(IODIG_OP_PRD, 2'h0, 6'h31, 16'h0000);
        rc(`IODIG_RA_ACC, 16'h7a9e);
        for (int c = 1; c < 4; c++) begin
            op(IODIG_OP_QWR, 2'(c), 6'h3f, 16'h8100 + 16'(c));
            op(IODIG_OP_QRD, 2'(c), 6'h3f, 16'h0000);
            rc(`IODIG_RA_ACC, 16'h0100 + 16'(c));
            chk(dma_ptr[(c-1)*16+:16], 16'h0100 + 16'(c));
        end
        wr(`IODIG_RA_PC, 16'h0123);
        wr(`IODIG_RA_VEC, 16'h0456);
        op(IODIG_OP_IEN, 2'h0, 6'h00, 16'h0000);
        mod_done <= 3'h2;
        @(posedge clock);
        mod_done <= 3'h0;
        op(IODIG_OP_QRD, 2'h2, 6'h3f, 16'h0000);
        rc(`IODIG_RA_ACC, 16'h8102);
        ft(1);
        rc(`IODIG_RA_SAVE, 16'h0123);
        rc(`IODIG_RA_PC, 16'h0456);
        rc(`IODIG_RA_STAT, 16'h0004);
        op(IODIG_OP_QWR, 2'h2, 6'h3f, 16'h0102);
        mod_event <= 3'h4;
        @(posedge clock);
        mod_event <= 3'h0;
        ft(1);
        op(IODIG_OP_IEN, 2'h0, 6'h00, 16'h0000);
        op(IODIG_OP_MASK, 2'h0, 6'h00, 16'h0003);
        ft(1);
        op(IODIG_OP_MASK, 2'h0, 6'h00, 16'h0002);
        mod_dma_req <= 3'h1;
        ft(1);
        op(IODIG_OP_MASK, 2'h0, 6'h00, 16'h0001);
        chk({13'h0000, mod_dma_go}, 16'h0000);
        ft(2);
        op(IODIG_OP_MASK, 2'h0, 6'h00, 16'h0000);
        chk({13'h0000, mod_dma_go}, 16'h0001);
        mod_dma_req <= 3'h0;
        power_fail <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            op(IODIG_OP_SKIP, 2'(c), 6'h3f, 16'h0000);
            rc(`IODIG_RA_STAT, (c % 3 == 0) ? 16'h0004 : 16'h000c);
        end
        test_done();
    end
endmodule
`default_nettype wire
